// ### uart_receive_status_flags.sv
// status flag logic of an asynchronous serial receiver with its register port
// Behaviour
// - loopback enable routes serial output into own receiver; clear means line input.
// - framing error flag sets when stop bit sampled low.
// - overrun flag sets when new character lands before old one read.
// - reading receive buffer clears overrun flag.
// - parity error sets on mismatch; reads zero while parity check disabled.
// - summary error sets on framing, parity or overrun error; break does not set it.
// - reading receive buffer clears summary error flag.
// - activity flag high while transmitting or receiving, else low.
// - buffer read clears error bits, address/idle flag and receive flag.
`timescale 1ns/1ps
module uart_receive_status_flags #(
    parameter int DATA_W = 8
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_srst,
    input  wire logic [2:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [7:0]        o_rdata,
    input  wire logic              i_rx_pin,
    input  wire logic              i_tx_serial,
    input  wire logic              i_tx_busy,
    input  wire logic              i_rx_busy,
    input  wire logic              i_char_done,
    input  wire logic [DATA_W-1:0] i_char_data,
    input  wire logic              i_stop_low,
    input  wire logic              i_parity_bad,
    input  wire logic              i_break_seen,
    input  wire logic              i_addr_mark,
    input  wire logic              i_idle_before,
    output logic                   o_rx_serial,
    output logic                   o_parity_check_enable,
    output logic                   o_receive_interrupt_flag,
    output logic                   o_irq
);
    logic              rx_meta_q;
    logic              rx_sync_q;
    logic              loopback_enable_q;
    logic              framing_error_flag_q;
    logic              overrun_flag_q;
    logic              parity_error_flag_q;
    logic              break_detect_flag_q;
    logic              summary_receive_error_flag_q;
    logic              address_char_flag_q;
    logic              activity_flag_q;
    logic              rx_full_q;
    logic [DATA_W-1:0] receive_buffer_q;
    logic [7:0]        ctrl_q;
    logic [2:0]        irq_st_q;
    logic [2:0]        irq_msk_q;
    logic              buf_rd;
    logic              stat_wr;
    logic              ovr_now;
    logic              pe_now;
    logic              err_now;
    logic              mark_now;
    logic [2:0]        irq_ev;

    // register port strobes
    assign buf_rd  = i_rd && (i_addr == uart_status_pkg::ADDR_RXBUF);
    assign stat_wr = i_wr && (i_addr == uart_status_pkg::ADDR_STATUS);

    // per-character error conditions
    assign ovr_now  = i_char_done && rx_full_q && !buf_rd;
    assign pe_now   = i_char_done && i_parity_bad && ctrl_q[uart_status_pkg::CTRL_PEN];
    assign err_now  = i_char_done && (i_stop_low || pe_now || ovr_now);
    assign mark_now = i_char_done
        && ((ctrl_q[uart_status_pkg::CTRL_MPADR] && i_addr_mark)
        || (ctrl_q[uart_status_pkg::CTRL_MPIDL] && i_idle_before));
    assign irq_ev   = {i_break_seen, err_now, i_char_done};

    // two-flop synchroniser on the line input
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end
        else
        begin
            rx_meta_q <= i_rx_pin;
            rx_sync_q <= rx_meta_q;
        end
    end

    // receiver input mux: internal loopback or line
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            o_rx_serial <= 1'b1;
        else
            o_rx_serial <= loopback_enable_q ? i_tx_serial : rx_sync_q;
    end

    // loopback enable bit, written through the status register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            loopback_enable_q <= 1'b0;
        else if (stat_wr)
            loopback_enable_q <= i_wdata[uart_status_pkg::BIT_LISTEN];
    end

    // control register: parity enable and multiprocessor mode selects
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            ctrl_q <= uart_status_pkg::CTRL_RST;
        else if (i_wr && (i_addr == uart_status_pkg::ADDR_CTRL))
            ctrl_q <= i_wdata;
    end

    // receive buffer and its full marker; a new character wins over a same-cycle read
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            receive_buffer_q <= '0;
            rx_full_q        <= 1'b0;
        end
        else if (i_char_done)
        begin
            receive_buffer_q <= i_char_data;
            rx_full_q        <= 1'b1;
        end
        else if (buf_rd)
            rx_full_q <= 1'b0;
    end

    // framing error: set by character, cleared by buffer read or status write
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            framing_error_flag_q <= 1'b0;
        else if (i_char_done && i_stop_low)
            framing_error_flag_q <= 1'b1;
        else if (buf_rd)
            framing_error_flag_q <= 1'b0;
        else if (stat_wr)
            framing_error_flag_q <= i_wdata[uart_status_pkg::BIT_FE];
    end

    // overrun: cleared only by buffer read, status writes are ignored
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            overrun_flag_q <= 1'b0;
        else if (ovr_now)
            overrun_flag_q <= 1'b1;
        else if (buf_rd)
            overrun_flag_q <= 1'b0;
    end

    // parity error, only while parity checking is enabled
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            parity_error_flag_q <= 1'b0;
        else if (pe_now)
            parity_error_flag_q <= 1'b1;
        else if (buf_rd)
            parity_error_flag_q <= 1'b0;
        else if (stat_wr)
            parity_error_flag_q <= i_wdata[uart_status_pkg::BIT_PE];
    end

    // break flag
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            break_detect_flag_q <= 1'b0;
        else if (i_break_seen)
            break_detect_flag_q <= 1'b1;
        else if (buf_rd)
            break_detect_flag_q <= 1'b0;
        else if (stat_wr)
            break_detect_flag_q <= i_wdata[uart_status_pkg::BIT_BRK];
    end

    // summary error: set with any of framing, parity, overrun; cleared by buffer read
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            summary_receive_error_flag_q <= 1'b0;
        else if (err_now)
            summary_receive_error_flag_q <= 1'b1;
        else if (buf_rd)
            summary_receive_error_flag_q <= 1'b0;
    end

    // address / idle indication
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            address_char_flag_q <= 1'b0;
        else if (mark_now)
            address_char_flag_q <= 1'b1;
        else if (buf_rd || i_char_done)
            address_char_flag_q <= 1'b0;
        else if (stat_wr)
            address_char_flag_q <= i_wdata[uart_status_pkg::BIT_ADDR];
    end

    // activity indication, read only
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            activity_flag_q <= 1'b0;
        else
            activity_flag_q <= i_tx_busy || i_rx_busy;
    end

    // receive interrupt flag follows the buffer full marker
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            o_receive_interrupt_flag <= 1'b0;
        else if (i_char_done)
            o_receive_interrupt_flag <= 1'b1;
        else if (buf_rd)
            o_receive_interrupt_flag <= 1'b0;
    end

    // parity enable exported to the receive shifter
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            o_parity_check_enable <= 1'b0;
        else
            o_parity_check_enable <= ctrl_q[uart_status_pkg::CTRL_PEN];
    end

    // sticky interrupt status, write one to clear, event wins over clear
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            irq_st_q <= uart_status_pkg::IRQ_RST;
        else if (i_wr && (i_addr == uart_status_pkg::ADDR_IRQ_ST))
            irq_st_q <= (irq_st_q & ~i_wdata[2:0]) | irq_ev;
        else
            irq_st_q <= irq_st_q | irq_ev;
    end

    // interrupt mask
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            irq_msk_q <= uart_status_pkg::IRQ_RST;
        else if (i_wr && (i_addr == uart_status_pkg::ADDR_IRQ_MSK))
            irq_msk_q <= i_wdata[2:0];
    end

    // level interrupt output
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            o_irq <= 1'b0;
        else
            o_irq <= |(irq_st_q & irq_msk_q);
    end

    // read data, valid in the cycle after the read strobe; unmapped reads zero
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            o_rdata <= 8'h00;
        else if (!i_rd)
            o_rdata <= 8'h00;
        else if (i_addr == uart_status_pkg::ADDR_STATUS)
            o_rdata <= {loopback_enable_q, framing_error_flag_q, overrun_flag_q,
                        parity_error_flag_q && ctrl_q[uart_status_pkg::CTRL_PEN],
                        break_detect_flag_q, summary_receive_error_flag_q,
                        address_char_flag_q, activity_flag_q};
        else if (i_addr == uart_status_pkg::ADDR_RXBUF)
            o_rdata <= 8'(receive_buffer_q);
        else if (i_addr == uart_status_pkg::ADDR_CTRL)
            o_rdata <= ctrl_q;
        else if (i_addr == uart_status_pkg::ADDR_IRQ_ST)
            o_rdata <= {5'h00, irq_st_q};
        else if (i_addr == uart_status_pkg::ADDR_IRQ_MSK)
            o_rdata <= {5'h00, irq_msk_q};
        else
            o_rdata <= 8'h00;
    end
endmodule

// ### uart_status_pkg.sv
// package with register offsets, bit positions and reset values of the status flag block
package uart_status_pkg;
    // register offsets on the plain register port
    localparam logic [2:0] ADDR_STATUS  = 3'h0;
    localparam logic [2:0] ADDR_RXBUF   = 3'h1;
    localparam logic [2:0] ADDR_CTRL    = 3'h2;
    localparam logic [2:0] ADDR_IRQ_ST  = 3'h3;
    localparam logic [2:0] ADDR_IRQ_MSK = 3'h4;
    // status register bit positions
    localparam int BIT_LISTEN = 7;
    localparam int BIT_FE     = 6;
    localparam int BIT_OE     = 5;
    localparam int BIT_PE     = 4;
    localparam int BIT_BRK    = 3;
    localparam int BIT_RXERR  = 2;
    localparam int BIT_ADDR   = 1;
    localparam int BIT_BUSY   = 0;
    // control register bit positions
    localparam int CTRL_PEN   = 0;
    localparam int CTRL_MPIDL = 1;
    localparam int CTRL_MPADR = 2;
    // interrupt status bits
    localparam int IRQ_RX     = 0;
    localparam int IRQ_ERR    = 1;
    localparam int IRQ_BRK    = 2;
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [2:0] IRQ_RST    = 3'h0;
endpackage

// ### uart_status_props.sv
// assertion checker of the receive status flag block, bound to its top
`timescale 1ns/1ps
module uart_status_props (
    input  wire logic       i_sys_clk,
    input  wire logic       i_srst,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] o_rdata,
    input  wire logic       i_tx_serial,
    input  wire logic       i_tx_busy,
    input  wire logic       i_rx_busy,
    input  wire logic       i_char_done,
    input  wire logic       i_stop_low,
    input  wire logic       i_break_seen,
    input  wire logic       o_rx_serial,
    input  wire logic       o_parity_check_enable,
    input  wire logic       o_receive_interrupt_flag
);
    logic loop_q;
    logic rd_st;
    logic rd_buf;
    logic act;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // decoded accesses and port activity
    assign rd_st  = i_rd && i_addr == uart_status_pkg::ADDR_STATUS;
    assign rd_buf = i_rd && i_addr == uart_status_pkg::ADDR_RXBUF;
    assign act    = i_tx_busy || i_rx_busy;
    // loopback setting as last written by software
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
            loop_q <= 1'b0;
        else if (i_wr && i_addr == uart_status_pkg::ADDR_STATUS)
            loop_q <= i_wdata[uart_status_pkg::BIT_LISTEN];
    end
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside its slot");
    a_unmapped_zero: assert property (i_rd && i_addr > 3'h4 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_frame_err: assert property (i_char_done && i_stop_low ##1 !rd_buf && !i_wr ##1 rd_st
        |=> o_rdata[6] && o_rdata[2])
        else $error("framing flags not set");
    a_parity_off: assert property (rd_st && !o_parity_check_enable ##1 !o_parity_check_enable |-> !o_rdata[4])
        else $error("parity flag seen while check off");
    a_rxflag_set: assert property (i_char_done |=> o_receive_interrupt_flag)
        else $error("receive flag not set");
    a_rxflag_clear: assert property (rd_buf && !i_char_done |=> !o_receive_interrupt_flag)
        else $error("receive flag not cleared by buffer read");
    a_read_clears: assert property (rd_buf && !i_char_done && !i_break_seen ##1 !i_char_done && !i_break_seen && !i_wr ##1 rd_st |=> o_rdata[6:1] == 6'h00)
        else $error("error flags survive buffer read");
    a_busy_flag: assert property (rd_st && !$past(i_srst) && act == $past(act) |=> o_rdata[0] == $past(act, 2))
        else $error("activity flag wrong");
    a_loop_select: assert property (loop_q && $past(loop_q) |=> o_rx_serial == $past(i_tx_serial))
        else $error("loopback path wrong");
    a_overrun_set: assert property (i_char_done && o_receive_interrupt_flag && !rd_buf ##1 !rd_buf ##1 rd_st |=> o_rdata[5] && o_rdata[2])
        else $error("overrun flags not set");
    c_buf_then_st: cover property (rd_buf ##2 rd_st);
    c_overrun: cover property (i_char_done && o_receive_interrupt_flag);
    c_loop: cover property (loop_q && i_tx_serial);
endmodule
bind uart_receive_status_flags uart_status_props u_uart_status_props (.*);

// ### uart_line_peer.sv
// remote serial peer that drives the receive line of the block
`timescale 1ns/1ps
module uart_line_peer #(
    parameter int BIT_CYC = 8
) (
    input  wire logic i_sys_clk,
    output logic      o_line
);
    // line rests high between frames
    initial o_line = 1'b1;
    // start bit, data lsb first, stop bit
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            o_line <= f[i];
            repeat (BIT_CYC) @(posedge i_sys_clk);
        end
    endtask
endmodule

// ### uart_receive_status_flags_tb_top.sv
// self-checking testbench of the receive status flag block
`timescale 1ns/1ps
module uart_receive_status_flags_tb_top;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] cdat = 8'h00;
    logic [5:0] ev = 6'h00;
    logic       wr = 1'b0, rd = 1'b0, txs = 1'b1, txb = 1'b0, rxb = 1'b0;
    logic [7:0] rdata;
    logic       line, rxs, pce, rxf, irq;
    int         n_mismatch = 0;
    int         total_checks = 0;
    // system clock, 100 ns period
    always #50 clk = ~clk;
    uart_receive_status_flags u_uart_receive_status_flags (.i_sys_clk(clk), .i_srst(srst),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_pin(line),
        .i_tx_serial(txs), .i_tx_busy(txb), .i_rx_busy(rxb), .i_char_done(ev[0]),
        .i_char_data(cdat), .i_stop_low(ev[1]), .i_parity_bad(ev[2]), .i_break_seen(ev[5]),
        .i_addr_mark(ev[3]), .i_idle_before(ev[4]), .o_rx_serial(rxs),
        .o_parity_check_enable(pce), .o_receive_interrupt_flag(rxf), .o_irq(irq));
    uart_line_peer u_uart_line_peer (.i_sys_clk(clk), .o_line(line));
    // compare and count
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // register port cycles and receiver events
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk($sformatf("reg%0d", a), rdata & m, e);
    endtask
    task automatic fire(input logic [5:0] e, input logic [7:0] d);
        ev <= e;
        cdat <= d;
        @(posedge clk);
        ev <= 6'h00;
        @(posedge clk);
    endtask
    // expected status after one character with parity check on
    function automatic logic [7:0] exp_st(input logic [5:0] e, input logic ov);
        return {1'b0, e[1], ov, e[2], 1'b0, e[1] | e[2] | ov, 2'b00};
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // main sequence; the status register is never written to drop overrun
    initial
    begin
        logic [7:0] d;
        logic [5:0] e;
        logic       ov;
        void'($urandom(32'h12d56454));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        for (int a = 0; a < 8; a++)
            rreg(a[2:0], 8'h00, 8'hff);
        wreg(uart_status_pkg::ADDR_STATUS, 8'h80);
        rreg(uart_status_pkg::ADDR_STATUS, 8'h80, 8'hff);
        for (int i = 0; i < 8; i++)
        begin
            txs <= 1'($urandom());
            repeat (3) @(posedge clk);
            chk("loop", {7'h00, rxs}, {7'h00, txs});
        end
        wreg(uart_status_pkg::ADDR_STATUS, 8'h00);
        d = 8'($urandom());
        fork
            u_uart_line_peer.send(d);
            for (int i = 0; i < 10; i++)
            begin
                repeat (6) @(posedge clk);
                chk("line", {7'h00, rxs}, {7'h00, i == 9 ? 1'b1 : i == 0 ? 1'b0 : d[i-1]});
                repeat (2) @(posedge clk);
            end
        join
        fire(6'h03, d);
        chk("irq", {7'h00, irq}, 8'h00);
        wreg(uart_status_pkg::ADDR_IRQ_MSK, 8'h02);
        // the level output lags the mask register by one more cycle
        @(posedge clk);
        chk("irq", {7'h00, irq}, 8'h01);
        rreg(uart_status_pkg::ADDR_STATUS, 8'h44, 8'hff);
        rreg(uart_status_pkg::ADDR_RXBUF, d, 8'hff);
        rreg(uart_status_pkg::ADDR_STATUS, 8'h00, 8'hff);
        chk("rxif", {7'h00, rxf}, 8'h00);
        wreg(uart_status_pkg::ADDR_IRQ_ST, 8'h07);
        repeat (2) @(posedge clk);
        chk("irq", {7'h00, irq}, 8'h00);
        fire(6'h05, d);
        rreg(uart_status_pkg::ADDR_STATUS, 8'h00, 8'h10);
        rreg(uart_status_pkg::ADDR_RXBUF, d, 8'hff);
        wreg(uart_status_pkg::ADDR_CTRL, 8'h01);
        // exported enable is a registered copy of the control bit
        @(posedge clk);
        chk("pce", {7'h00, pce}, 8'h01);
        // random characters, every fourth one overrun by a second
        for (int i = 0; i < 24; i++)
        begin
            d = 8'($urandom());
            e = {3'h0, 2'($urandom()), 1'b1};
            ov = (i % 4 == 3);
            fire(e, d);
            if (ov)
                fire(6'h01, ~d);
            rreg(uart_status_pkg::ADDR_STATUS, exp_st(e, ov), 8'hff);
            rreg(uart_status_pkg::ADDR_RXBUF, ov ? ~d : d, 8'hff);
            rreg(uart_status_pkg::ADDR_STATUS, 8'h00, 8'hff);
        end
        fire(6'h20, d);
        rreg(uart_status_pkg::ADDR_STATUS, 8'h08, 8'hff);
        rreg(uart_status_pkg::ADDR_RXBUF, 8'h00, 8'h00);
        for (int m = 0; m < 2; m++)
        begin
            txb <= (m == 0);
            rxb <= (m == 1);
            wreg(uart_status_pkg::ADDR_CTRL, m == 0 ? 8'h05 : 8'h03);
            fire(m == 0 ? 6'h09 : 6'h11, d);
            rreg(uart_status_pkg::ADDR_STATUS, 8'h03, 8'hff);
            rreg(uart_status_pkg::ADDR_RXBUF, d, 8'hff);
        end
        txb <= 1'b0;
        rxb <= 1'b0;
        // activity flag is registered, let it settle before reading
        @(posedge clk);
        rreg(uart_status_pkg::ADDR_STATUS, 8'h00, 8'hff);
        results();
    end
    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        results();
    end
endmodule
